// ===== global_cfg_regs.vh
/*
 * holds the offsets, field positions, reset values and codes of the global
 * configuration register bank of the eight-channel uart.
 * assumes it is included by its bare name from the design files.
 */
`ifndef GLOBAL_CFG_REGS_VH
`define GLOBAL_CFG_REGS_VH

`define ADDR_PENDING_SUMMARY  8'h80
`define ADDR_SRC_CODES_LOW    8'h81
`define ADDR_SRC_CODES_MID    8'h82
`define ADDR_SRC_CODES_HIGH   8'h83
`define ADDR_TIMER_CONTROL    8'h84
`define ADDR_TIMER_RSVD       8'h85
`define ADDR_TIMER_COUNT_LOW  8'h86
`define ADDR_TIMER_COUNT_HIGH 8'h87
`define ADDR_OVERSAMPLE_SEL   8'h88
`define ADDR_RSVD_ZERO_A      8'h89
`define ADDR_CHAN_SOFT_RESET  8'h8A
`define ADDR_CHAN_SLEEP_EN    8'h8B
`define ADDR_REVISION_CODE    8'h8C
`define ADDR_DEVICE_ID_CODE   8'h8D
`define ADDR_BROADCAST_WRITE  8'h8E

`define RST_SUMMARY           8'h00
`define RST_SRC_CODES         24'h000000
`define RST_TIMER_CONTROL     4'h0
`define RST_TIMER_COUNT       16'h0000
`define RST_OVERSAMPLE        8'h00
`define RST_SLEEP_EN          8'h00
`define RST_BROADCAST         1'h0
`define SLEEP_ALL_CHANNELS    8'hFF

`define TCTL_IRQ_EN_BIT       0
`define TCTL_START_BIT        1
`define TCTL_ONESHOT_BIT      2
`define TCTL_CLKSEL_BIT       3
`define TCTL_WIDTH            4
`define BCAST_ALL_BIT         0

`define CODE_WIDTH            3
`define CODE_NONE             3'h0
`define CODE_RX_DATA_LINE     3'h1
`define CODE_RX_TIMEOUT       3'h2
`define CODE_TX_EMPTY         3'h3
`define CODE_MODEM_FLOW       3'h4
`define CODE_TIMER            3'h7

`endif

// ===== chan_src_encoder.v
/*
 * priority encoder turning one channel's enabled interrupt causes into
 * its 3-bit source code.
 * assumes causes arrive already gated by the channel's own enable register.
 */
`include "global_cfg_regs.vh"

module chan_src_encoder #(
    parameter ALLOW_TIMER = 0
) (
    input  wire       rxDataLine,
    input  wire       rxTimeout,
    input  wire       txEmpty,
    input  wire       modemFlow,
    input  wire       timerIrq,
    output reg  [2:0] srcCode
);
    always @* begin
        if (rxDataLine) begin
            srcCode = `CODE_RX_DATA_LINE;
        end else if (rxTimeout) begin
            srcCode = `CODE_RX_TIMEOUT;
        end else if (txEmpty) begin
            srcCode = `CODE_TX_EMPTY;
        end else if (modemFlow) begin
            srcCode = `CODE_MODEM_FLOW;
        end else if ((ALLOW_TIMER != 0) && timerIrq) begin
            srcCode = `CODE_TIMER;
        end else begin
            srcCode = `CODE_NONE;
        end
    end
endmodule // chan_src_encoder

// ===== global_config_interrupt_regs.v
/*
 * global configuration register bank of the eight-channel uart: interrupt
 * summary and source codes, timer control/count storage, oversampling,
 * per-channel soft reset, sleep enable, revision, id and broadcast bit.
 * assumes the per-channel uarts supply their interrupt causes already gated
 * by their own enable registers, on clk_sys, and that the timer and sleep
 * logic report their events as pulses on the same clock.
 */
`include "global_cfg_regs.vh"

module global_config_interrupt_regs #(
    parameter NUM_CH   = 8,
    parameter REV_CODE = 8'h01,   // arbitrary value
    parameter DEV_ID   = 8'h5A    // arbitrary value
) (
    input  wire                clk_sys,
    input  wire                rst_b,
    input  wire [7:0]          busAddr,
    input  wire [7:0]          busWrData,
    input  wire                busRdStrobe,
    input  wire                busWrStrobe,
    output reg  [7:0]          busRdData,
    input  wire [NUM_CH-1:0]   chRxDataLine,
    input  wire [NUM_CH-1:0]   chRxTimeout,
    input  wire [NUM_CH-1:0]   chTxEmpty,
    input  wire [NUM_CH-1:0]   chModemFlow,
    input  wire                timerExpire,
    input  wire                wakeEvent,
    output wire                irqOut,
    output reg  [NUM_CH-1:0]   chSoftReset,
    output wire [NUM_CH-1:0]   chOversample8x,
    output wire [NUM_CH-1:0]   chSleepEnable,
    output wire                timerStart,
    output wire                timerOneShot,
    output wire                timerExtClock,
    output wire [15:0]         timerCount,
    output wire                broadcastWrite
);
    reg  [`TCTL_WIDTH-1:0] timerCtl_r;
    reg  [15:0]            timerCount_r;
    reg  [NUM_CH-1:0]      oversample_r;
    reg  [NUM_CH-1:0]      sleepEn_r;
    reg                    broadcast_r;
    reg                    timerPend_r;
    reg                    wakePend_r;
    reg                    allAsleep_r;
    reg  [NUM_CH-1:0]      summary_r;
    reg  [3*NUM_CH-1:0]    srcCodes_r;
    reg  [7:0]             rdData_nxt;
    wire [3*NUM_CH-1:0]    srcCodes;
    wire [NUM_CH-1:0]      summary;
    wire                   rdTimerCtl;
    wire                   rdSummary;
    wire                   wrHit;

    assign rdTimerCtl = busRdStrobe && (busAddr == `ADDR_TIMER_CONTROL);
    assign rdSummary  = busRdStrobe && (busAddr == `ADDR_PENDING_SUMMARY);
    assign wrHit      = busWrStrobe;

    // per-channel priority encoders; only channel 0 may carry the timer code
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : gEnc
            chan_src_encoder #(
                .ALLOW_TIMER (ch == 0)
            ) uEnc (
                .rxDataLine  (chRxDataLine[ch]),
                .rxTimeout   (chRxTimeout[ch]),
                .txEmpty     (chTxEmpty[ch]),
                .modemFlow   (chModemFlow[ch]),
                .timerIrq    (timerPend_r),
                .srcCode     (srcCodes[3*ch+2:3*ch])
            );
            assign summary[ch] = |srcCodes[3*ch+2:3*ch];
        end
    endgenerate

    // codes and summary are captured in the same register stage so a read
    // never sees the two views disagree
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            summary_r  <= `RST_SUMMARY;
            srcCodes_r <= `RST_SRC_CODES;
        end else begin
            summary_r  <= summary;
            srcCodes_r <= srcCodes;
        end
    end

    // timer interrupt: set wins over the read that clears it
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timerPend_r <= 1'b0;
        end else if (timerExpire && timerCtl_r[`TCTL_IRQ_EN_BIT]) begin
            timerPend_r <= 1'b1;
        end else if (rdTimerCtl) begin
            timerPend_r <= 1'b0;
        end
    end

    // wake-up interrupt only after a full sleep of all channels
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            allAsleep_r <= 1'b0;
            wakePend_r  <= 1'b0;
        end else begin
            if (sleepEn_r == `SLEEP_ALL_CHANNELS && summary == {NUM_CH{1'b0}}) begin
                allAsleep_r <= 1'b1;
            end else if (wakeEvent || sleepEn_r != `SLEEP_ALL_CHANNELS) begin
                allAsleep_r <= 1'b0;
            end
            if (wakeEvent && allAsleep_r) begin
                wakePend_r <= 1'b1;
            end else if (rdSummary) begin
                wakePend_r <= 1'b0;
            end
        end
    end

    // writable registers; soft-reset bits last one cycle then clear
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timerCtl_r   <= `RST_TIMER_CONTROL;
            timerCount_r <= `RST_TIMER_COUNT;
            oversample_r <= `RST_OVERSAMPLE;
            sleepEn_r    <= `RST_SLEEP_EN;
            broadcast_r  <= `RST_BROADCAST;
            chSoftReset  <= {NUM_CH{1'b0}};
        end else begin
            chSoftReset <= {NUM_CH{1'b0}};
            if (wrHit) begin
                case (busAddr)
                    `ADDR_TIMER_CONTROL: begin
                        timerCtl_r <= busWrData[`TCTL_WIDTH-1:0];
                    end
                    `ADDR_TIMER_COUNT_LOW: begin
                        timerCount_r[7:0] <= busWrData;
                    end
                    `ADDR_TIMER_COUNT_HIGH: begin
                        timerCount_r[15:8] <= busWrData;
                    end
                    `ADDR_OVERSAMPLE_SEL: begin
                        oversample_r <= busWrData[NUM_CH-1:0];
                    end
                    `ADDR_CHAN_SOFT_RESET: begin
                        chSoftReset <= busWrData[NUM_CH-1:0];
                    end
                    `ADDR_CHAN_SLEEP_EN: begin
                        sleepEn_r <= busWrData[NUM_CH-1:0];
                    end
                    `ADDR_BROADCAST_WRITE: begin
                        broadcast_r <= busWrData[`BCAST_ALL_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // read mux; write-only and reserved locations read zero
    always @* begin
        rdData_nxt = 8'h00;
        case (busAddr)
            `ADDR_PENDING_SUMMARY:  rdData_nxt = summary_r;
            `ADDR_SRC_CODES_LOW:    rdData_nxt = srcCodes_r[7:0];
            `ADDR_SRC_CODES_MID:    rdData_nxt = srcCodes_r[15:8];
            `ADDR_SRC_CODES_HIGH:   rdData_nxt = srcCodes_r[23:16];
            `ADDR_TIMER_CONTROL:    rdData_nxt = {4'h0, timerCtl_r};
            `ADDR_TIMER_COUNT_LOW:  rdData_nxt = timerCount_r[7:0];
            `ADDR_TIMER_COUNT_HIGH: rdData_nxt = timerCount_r[15:8];
            `ADDR_OVERSAMPLE_SEL:   rdData_nxt = oversample_r;
            `ADDR_CHAN_SLEEP_EN:    rdData_nxt = sleepEn_r;
            `ADDR_REVISION_CODE:    rdData_nxt = REV_CODE;
            `ADDR_DEVICE_ID_CODE:   rdData_nxt = DEV_ID;
            `ADDR_BROADCAST_WRITE:  rdData_nxt = {7'h00, broadcast_r};
            default:                rdData_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            busRdData <= 8'h00;
        end else if (busRdStrobe) begin
            busRdData <= rdData_nxt;
        end
    end

    assign irqOut         = (|summary_r) || wakePend_r;
    assign chOversample8x = oversample_r;
    assign chSleepEnable  = sleepEn_r;
    assign timerStart     = timerCtl_r[`TCTL_START_BIT];
    assign timerOneShot   = timerCtl_r[`TCTL_ONESHOT_BIT];
    assign timerExtClock  = timerCtl_r[`TCTL_CLKSEL_BIT];
    assign timerCount     = timerCount_r;
    assign broadcastWrite = broadcast_r;
endmodule // global_config_interrupt_regs

// ===== gcir_chk.sv
/* concurrent checks on the global register bank: bus reads, soft reset, irq.
   assumes it is bound to the bank and sees only the bank's ports. */
module gcir_chk #(
    parameter NUM_CH   = 8,
    parameter REV_CODE = 8'h01
) (
    input logic              clk_sys,
    input logic              rst_b,
    input logic [7:0]        busAddr,
    input logic [7:0]        busWrData,
    input logic              busRdStrobe,
    input logic              busWrStrobe,
    input logic [7:0]        busRdData,
    input logic [NUM_CH-1:0] chRxDataLine,
    input logic [NUM_CH-1:0] chRxTimeout,
    input logic [NUM_CH-1:0] chTxEmpty,
    input logic [NUM_CH-1:0] chModemFlow,
    input logic              irqOut,
    input logic [NUM_CH-1:0] chSoftReset,
    input logic [NUM_CH-1:0] chOversample8x
);
    wire [NUM_CH-1:0] anyCause = chRxDataLine | chRxTimeout | chTxEmpty | chModemFlow;
    wire [2:0]        ch1Code  = chRxDataLine[1] ? 3'h1 : chRxTimeout[1] ? 3'h2 :
                                 chTxEmpty[1] ? 3'h3 : chModemFlow[1] ? 3'h4 : 3'h0;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // the written bits show for exactly one cycle, then drop
    sequence softPulse;
        chSoftReset == $past(busWrData) ##1 chSoftReset == 8'h00;
    endsequence
    a_irq_follows: assert property (|anyCause |=> irqOut)
        else $error("irq output low with a channel cause pending");
    // channel 0 may also carry the timer code, which this checker cannot see
    a_sum_read: assert property (busRdStrobe && busAddr == 8'h80 |=> busRdData[7:1] == $past(anyCause[7:1], 2))
        else $error("summary read differs from channel causes");
    a_code_ch1: assert property (busRdStrobe && busAddr == 8'h81 |=> busRdData[5:3] == $past(ch1Code, 2))
        else $error("channel 1 source code wrong");
    a_rsvd_zero: assert property (busRdStrobe && (busAddr == 8'h85 || busAddr == 8'h89 || busAddr == 8'h8A) |=> busRdData == 8'h00)
        else $error("reserved or write-only place read nonzero");
    a_rev_read: assert property (busRdStrobe && busAddr == 8'h8C |=> busRdData == REV_CODE)
        else $error("revision read wrong");
    a_soft_pulse: assert property (busWrStrobe && busAddr == 8'h8A |=> softPulse)
        else $error("soft reset pulse wrong");
    a_soft_idle: assert property (!(busWrStrobe && busAddr == 8'h8A) |=> chSoftReset == 8'h00)
        else $error("soft reset without a write");
    a_ovs_write: assert property (busWrStrobe && busAddr == 8'h88 |=> chOversample8x == $past(busWrData))
        else $error("oversample select not written");
endmodule // gcir_chk

bind global_config_interrupt_regs gcir_chk #(.NUM_CH(NUM_CH), .REV_CODE(REV_CODE)) gcir_chk_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .busAddr(busAddr), .busWrData(busWrData),
    .busRdStrobe(busRdStrobe), .busWrStrobe(busWrStrobe), .busRdData(busRdData),
    .chRxDataLine(chRxDataLine), .chRxTimeout(chRxTimeout), .chTxEmpty(chTxEmpty),
    .chModemFlow(chModemFlow), .irqOut(irqOut), .chSoftReset(chSoftReset),
    .chOversample8x(chOversample8x));

// ===== gcir_host.sv
/* host processor model on the parallel register bus.
   assumes the bank takes a strobe at a rising edge and answers at that same edge. */
module gcir_host (
    input  logic       clk_sys,
    input  logic [7:0] busRdData,
    output logic [7:0] busAddr = 8'h00,
    output logic [7:0] busWrData = 8'h00,
    output logic       busRdStrobe = 1'b0,
    output logic       busWrStrobe = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // released lines are inverted so a stale value is never read as valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        busAddr = a;
        busWrData = d;
        busWrStrobe = 1'b1;
        @(negedge clk_sys);
        busWrStrobe = 1'b0;
        busAddr = ~a;
        busWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        busAddr = a;
        busRdStrobe = 1'b1;
        @(negedge clk_sys);
        busRdStrobe = 1'b0;
        busAddr = ~a;
        d = busRdData; // a summary read also acknowledges a wake-up
    endtask
endmodule // gcir_host

// ===== global_config_interrupt_regs_tb_top.sv
/* self-checking bench: reset values, access kinds, random causes, timer, wake.
   assumes the host model and the bound checker are compiled beside it. */
module global_config_interrupt_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0, rst_b = 1'b0, timerExpire = 1'b0, wakeEvent = 1'b0;
    logic [7:0]  rxC = 0, toC = 0, txC = 0, mfC = 0, busAddr, busWrData, busRdData, rdv;
    logic        busRdStrobe, busWrStrobe, irqOut, tStart, tOne, tExt, bcast;
    logic [7:0]  softRst, ovs, sleepEn, wdat [15];
    logic [7:0]  mask [15] = '{0, 0, 0, 0, 8'h0F, 0, 8'hFF, 8'hFF, 8'hFF, 0, 0, 8'hFF, 0, 0, 8'h01};
    logic [15:0] tCount;
    logic [31:0] lfsr = 32'h0000_02A6;
    int          failures = 0, cmp_count = 0, word, sum;
    always #10 clk_sys = ~clk_sys;
    global_config_interrupt_regs #(.REV_CODE(8'h3C), .DEV_ID(8'hC3)) global_config_interrupt_regs_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .busAddr(busAddr), .busWrData(busWrData),
        .busRdStrobe(busRdStrobe), .busWrStrobe(busWrStrobe), .busRdData(busRdData),
        .chRxDataLine(rxC), .chRxTimeout(toC), .chTxEmpty(txC), .chModemFlow(mfC),
        .timerExpire(timerExpire), .wakeEvent(wakeEvent), .irqOut(irqOut),
        .chSoftReset(softRst), .chOversample8x(ovs), .chSleepEnable(sleepEn),
        .timerStart(tStart), .timerOneShot(tOne), .timerExtClock(tExt),
        .timerCount(tCount), .broadcastWrite(bcast));
    gcir_host gcir_host_inst (.clk_sys(clk_sys), .busRdData(busRdData), .busAddr(busAddr),
        .busWrData(busWrData), .busRdStrobe(busRdStrobe), .busWrStrobe(busWrStrobe));
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int enc(int c);
        return rxC[c] ? 1 : toC[c] ? 2 : txC[c] ? 3 : mfC[c] ? 4 : 0;
    endfunction
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask
    task automatic rdChk(logic [7:0] a, logic [7:0] exp);
        gcir_host_inst.rd(a, rdv);
        chk($sformatf("read %h", a), {8'h00, exp}, {8'h00, rdv});
    endtask
    task automatic pulse(bit w);
        @(negedge clk_sys);
        if (w) wakeEvent = 1'b1;
        else timerExpire = 1'b1;
        @(negedge clk_sys);
        wakeEvent = 1'b0;
        timerExpire = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1'b1;
        for (int a = 8'h80; a <= 8'h8F; a++)
            rdChk(a, a == 8'h8C ? 8'h3C : a == 8'h8D ? 8'hC3 : 8'h00);
        for (int a = 8'h80; a <= 8'h8E; a++) begin
            lfsr = nextRand(nextRand(lfsr));
            wdat[a-8'h80] = lfsr[7:0];
            gcir_host_inst.wr(a, lfsr[7:0]);
        end
        for (int a = 8'h80; a <= 8'h8E; a++)
            if (a < 8'h8C || a == 8'h8E) rdChk(a, wdat[a-8'h80] & mask[a-8'h80]);
        chk("count", {wdat[7], wdat[6]}, tCount);
        chk("ctl", {wdat[8], 4'h0, wdat[4][3:1], wdat[14][0]},
            {ovs, 4'h0, tExt, tOne, tStart, bcast});
        chk("sleep", {8'h00, wdat[11]}, {8'h00, sleepEn});
        gcir_host_inst.wr(8'h84, 8'h00);
        gcir_host_inst.wr(8'h8B, 8'h00);
        for (int i = 0; i < 24; i++) begin
            lfsr = nextRand(nextRand(nextRand(lfsr)));
            {rxC, toC, txC, mfC} = (i == 23) ? 32'h0 : lfsr;
            repeat (2) @(negedge clk_sys);
            word = 0;
            sum = 0;
            for (int c = 0; c < 8; c++) begin
                word |= enc(c) << (3 * c);
                sum |= (enc(c) != 0) << c;
            end
            chk("irq", 16'(sum != 0), {15'h0, irqOut});
            rdChk(8'h80, 8'(sum));
            for (int r = 0; r < 3; r++) rdChk(8'h81 + r, 8'(word >> (8 * r)));
        end
        gcir_host_inst.wr(8'h84, 8'h01);
        pulse(0);
        rdChk(8'h80, 8'h01);
        rdChk(8'h81, 8'h07);
        rxC = 8'h01;
        repeat (2) @(negedge clk_sys);
        rdChk(8'h81, 8'h01);
        rxC = 8'h00;
        rdChk(8'h84, 8'h01);
        repeat (2) @(negedge clk_sys);
        rdChk(8'h80, 8'h00);
        gcir_host_inst.wr(8'h84, 8'h00);
        pulse(0);
        rdChk(8'h80, 8'h00);
        gcir_host_inst.wr(8'h8B, 8'hFF);
        pulse(1);
        chk("wake", 16'h1, {15'h0, irqOut});
        rdChk(8'h80, 8'h00);
        chk("wake ack", 16'h0, {15'h0, irqOut});
        gcir_host_inst.wr(8'h8B, 8'h7F);
        pulse(1);
        chk("no wake", 16'h0, {15'h0, irqOut});
        test_done;
    end
    initial begin
        repeat (4000) @(posedge clk_sys);
        failures++;
        test_done;
    end
endmodule // global_config_interrupt_regs_tb_top
